// [bench/osp_osc_ctrl_asserts.sv]
// Concurrent checks on the oscillator block ports
`timescale 1ns/1ps
module osp_osc_ctrl_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic cfg_programmed,
  input wire logic [2:0] initial_osc_sel,
  input wire logic [1:0] primary_osc_mode_sel,
  input wire logic fosc_tick,
  input wire logic fcy_tick,
  input wire logic periph_tick,
  input wire logic wdt_ref_tick,
  input wire logic fail_safe_clock_monitor_ref_tick,
  input wire logic [2:0] cur_osc_sel,
  input wire logic pll_active,
  input wire logic osc_out_pin_oe
);
  logic [3:0] up_cnt;

  // Cycles since reset release, saturating
  always_ff @(posedge clk)
  begin
    if (srst)
      up_cnt <= 4'h0;
    else if (up_cnt != 4'hF)
      up_cnt <= up_cnt + 4'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence cur_settled;
    $stable(cur_osc_sel) [*3];
  endsequence

  sequence released;
    $fell(srst);
  endsequence

  a_periph_fcy_eq: assert property (periph_tick == fcy_tick)
    else $error("periph tick differs from fcy tick");
  a_fcy_from_fosc: assert property (fcy_tick |-> $past(fosc_tick, 2))
    else $error("fcy tick without fosc tick");
  a_ref_ticks_same: assert property (wdt_ref_tick == fail_safe_clock_monitor_ref_tick)
    else $error("watchdog and monitor references differ");
  a_pll_flag_match: assert property (cur_settled |->
    pll_active == (cur_osc_sel == 3'h1 || cur_osc_sel == 3'h3))
    else $error("pll flag does not match source");
  a_erased_start: assert property (released |-> cur_osc_sel == 3'h7 && !fosc_tick)
    else $error("source after reset not 7");
  a_cfg_capture: assert property (released |->
    ##[1:3] cur_osc_sel == (cfg_programmed ? initial_osc_sel : 3'h7))
    else $error("configured source not taken");
  a_pin_off_xtal: assert property (cur_settled ##0 (cur_osc_sel[2:1] == 2'h1 &&
    primary_osc_mode_sel inside {2'h1, 2'h2}) |-> !osc_out_pin_oe)
    else $error("pin driven in crystal mode");
  a_switch_gap: assert property ((up_cnt == 4'hF) && $changed(cur_osc_sel)
    |-> !$past(fosc_tick))
    else $error("fosc tick just before source change");
  a_no_pll_hop: assert property (cur_osc_sel inside {3'h1, 3'h3} |=>
    cur_osc_sel == $past(cur_osc_sel) || !(cur_osc_sel inside {3'h1, 3'h3}))
    else $error("direct hop between pll modes");
endmodule

bind osp_osc_ctrl osp_osc_ctrl_asserts u_chk (.clk, .srst, .cfg_programmed, .initial_osc_sel,
  .primary_osc_mode_sel, .fosc_tick, .fcy_tick, .periph_tick, .wdt_ref_tick, .fail_safe_clock_monitor_ref_tick,
  .cur_osc_sel, .pll_active, .osc_out_pin_oe);

// [bench/osp_xtal_model.sv]
// Free-running primary and secondary crystal model
`timescale 1ns/1ps
module osp_xtal_model #(
  parameter int PRI_DIV = 13,
  parameter int SEC_DIV = 100
) (
  input wire logic clk,
  output logic primary_tick = 1'b0,
  output logic secondary_tick = 1'b0
);
  int pri_cnt = 0;
  int sec_cnt = 0;

  // Crystals run free, one pulse per period
  always @(posedge clk)
  begin
    pri_cnt <= (pri_cnt == PRI_DIV - 1) ? 0 : pri_cnt + 1;
    sec_cnt <= (sec_cnt == SEC_DIV - 1) ? 0 : sec_cnt + 1;
    primary_tick <= (pri_cnt == PRI_DIV - 1);
    secondary_tick <= (sec_cnt == SEC_DIV - 1);
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the oscillator block
`timescale 1ns/1ps
`include "osp_map.svh"
module testbench import osp_pkg::*;;
  localparam int W = 4000;
  localparam real F = W * 7370.0 / 125000.0;
  logic clk = 1'b0;
  logic srst = 1'b1;
  osp_bus_req_t bus = '0;
  logic [15:0] rdata;
  logic cfg_programmed = 1'b1;
  logic [2:0] initial_osc_sel = 3'h0;
  logic [1:0] primary_osc_mode_sel = 2'h1;
  logic osc_pin_function_cfg = 1'b0;
  logic primary_tick, secondary_tick, fosc_tick, fcy_tick, periph_tick;
  logic wdt_ref_tick, fail_safe_clock_monitor_ref_tick, pll_active, osc_out_pin_o, osc_out_pin_oe;
  logic [2:0] cur_osc_sel;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int nf, nc, nw, np;
  logic pin_q;
  logic [15:0] d;
  logic [2:0] modes [5] = '{3'h7, 3'h6, 3'h4, 3'h2, 3'h3};
  real exp_f [5] = '{F / 2.0, F / 16.0, W / 100.0, W / 13.0, W * 8.0 / 13.0};

  always #4 clk = ~clk;

  osp_xtal_model u_xtal (.clk, .primary_tick, .secondary_tick);
  osp_osc_ctrl u_dut (.clk, .srst, .bus, .rdata, .cfg_programmed, .initial_osc_sel,
    .primary_osc_mode_sel, .osc_pin_function_cfg, .primary_tick, .secondary_tick,
    .fosc_tick, .fcy_tick, .periph_tick, .wdt_ref_tick, .fail_safe_clock_monitor_ref_tick, .cur_osc_sel,
    .pll_active, .osc_out_pin_o, .osc_out_pin_oe);

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rate(input string nm, input real e, input int g);
    n_tests++;
    if (g < e - e / 50.0 - 2.0 || g > e + e / 50.0 + 2.0)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0.1f seen %0d", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Count fosc, fcy and watchdog reference ticks over n cycles
  task automatic measure(input int n);
    nf = 0;
    nc = 0;
    nw = 0;
    np = 0;
    pin_q = osc_out_pin_o;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (osc_out_pin_o !== pin_q)
        np++;
      pin_q = osc_out_pin_o;
      if (fosc_tick === 1'b1)
        nf++;
      if (fcy_tick === 1'b1)
        nc++;
      if (wdt_ref_tick === 1'b1)
        nw++;
    end
  endtask

  // Request a source change and poll until the request bit drops
  task automatic sw(input logic [2:0] c);
    int k;
    wr(`OSP_ADDR_OSC_CTRL, {5'h00, c, 8'h01});
    k = 0;
    d = 16'h0001;
    while (d[0] !== 1'b0 && k < 20)
    begin
      rd(`OSP_ADDR_OSC_CTRL, d);
      k++;
    end
    repeat (2) @(posedge clk);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`OSP_ADDR_CFG_STAT, d);
    chk("cfg_stat", 16'h0001, d);
    rd(`OSP_ADDR_OSC_CTRL, d);
    chk("osc_ctrl", 16'h0000, d & 16'h7021);
    rd(`OSP_ADDR_CLK_DIV, d);
    chk("clk_div_rst", 16'h0040, d);
    rd(`OSP_ADDR_PLL_FBD, d);
    chk("pll_fbd_rst", 16'h0030, d);
    rd(`OSP_ADDR_FRC_TUNE, d);
    chk("frc_tune_rst", 16'h0000, d);
    wr(8'h20, 16'hFFFF);
    rd(8'h20, d);
    chk("unmapped", 16'h0000, d);
    wr(`OSP_ADDR_CLK_DIV, 16'hFFFF);
    rd(`OSP_ADDR_CLK_DIV, d);
    chk("clk_div_mask", 16'h07DF, d);
    wr(`OSP_ADDR_CLK_DIV, 16'h0100);
    wr(`OSP_ADDR_PLL_FBD, 16'h001E);
    measure(W);
    chk_rate("fosc_frc", F, nf);
    chk_rate("fcy", nf / 2.0, nc);
    chk_rate("pin_wave", nf / 2.0, np);
    chk("pin_oe", 16'h0001, {15'h0, osc_out_pin_oe});
    wr(`OSP_ADDR_FRC_TUNE, 16'h001F);
    measure(W);
    chk_rate("fosc_tuned", F + W * 31.0 * 3864.0 / 16777216.0, nf);
    wr(`OSP_ADDR_FRC_TUNE, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      sw(modes[i]);
      chk("cur_sel", {13'h0, modes[i]}, {13'h0, cur_osc_sel});
      measure(W);
      chk_rate("fosc_mode", exp_f[i], nf);
    end
    chk("pll_active", 16'h0001, {15'h0, pll_active});
    chk("pin_oe_xtal", 16'h0000, {15'h0, osc_out_pin_oe});
    wr(`OSP_ADDR_CLK_DIV, 16'h0140);
    measure(W);
    chk_rate("fosc_held", exp_f[4], nf);
    sw(3'h1);
    rd(`OSP_ADDR_OSC_CTRL, d);
    chk("refused", 16'h3008, d & 16'h7008);
    wr(`OSP_ADDR_OSC_CTRL, 16'h0008);
    rd(`OSP_ADDR_OSC_CTRL, d);
    chk("refused_clr", 16'h0000, d & 16'h0008);
    sw(3'h0);
    sw(3'h1);
    measure(W);
    chk_rate("fosc_frc_pll", F * 32.0 / 8.0, nf);
    sw(3'h5);
    measure(20000);
    chk_rate("wdt_ref", 20000.0 * 32768.0 / 125.0e6, nw);
    chk("low_power_rc_osc_sel", 16'h0005, {13'h0, cur_osc_sel});
    @(posedge clk);
    cfg_programmed <= 1'b0;
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("erased_sel", 16'h0007, {13'h0, cur_osc_sel});
    report_and_stop();
  end
endmodule

// [design/osp_osc_ctrl.sv]
// Oscillator source selection, fast RC postscaler, PLL and instruction clock
`timescale 1ns/1ps
`include "osp_map.svh"
module osp_osc_ctrl
  import osp_pkg::*;
#(
  parameter logic [23:0] TUNE_STEP = 24'd3864
) (
  input wire logic clk,
  input wire logic srst,
  input wire osp_bus_req_t bus,
  output logic [15:0] rdata,
  input wire logic cfg_programmed,
  input wire logic [2:0] initial_osc_sel,
  input wire logic [1:0] primary_osc_mode_sel,
  input wire logic osc_pin_function_cfg,
  input wire logic primary_tick,
  input wire logic secondary_tick,
  output logic fosc_tick,
  output logic fcy_tick,
  output logic periph_tick,
  output logic wdt_ref_tick,
  output logic fail_safe_clock_monitor_ref_tick,
  output logic [2:0] cur_osc_sel,
  output logic pll_active,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe
);

  localparam int PB = `OSP_PHASE_BITS;
  localparam logic [23:0] FRC_INC =
    24'((64'(`OSP_FRC_KHZ) << PB) / 64'(`OSP_CLK_KHZ));
  localparam logic [23:0] LOW_POWER_RC_OSC_INC =
    24'((64'(`OSP_LOW_POWER_RC_OSC_HZ) << PB) / (64'(`OSP_CLK_KHZ) * 64'd1000));

  function automatic logic [8:0] frc_post_div(input logic [2:0] code);
    unique case (code)
      3'h0: frc_post_div = 9'd1;
      3'h1: frc_post_div = 9'd2;
      3'h2: frc_post_div = 9'd4;
      3'h3: frc_post_div = 9'd8;
      3'h4: frc_post_div = 9'd16;
      3'h5: frc_post_div = 9'd32;
      3'h6: frc_post_div = 9'd64;
      3'h7: frc_post_div = 9'd256;
    endcase
  endfunction

  function automatic logic [3:0] pll_post_div(input logic [1:0] code);
    unique case (code)
      `OSP_POST_DIV2: pll_post_div = 4'd2;
      `OSP_POST_DIV8: pll_post_div = 4'd8;
      default: pll_post_div = 4'd4;
    endcase
  endfunction

  function automatic logic is_pll_sel(input logic [2:0] sel);
    is_pll_sel = (sel == `OSP_SEL_FRC_PLL) || (sel == `OSP_SEL_PRI_PLL);
  endfunction

  // Software-visible settings
  logic [15:0] clk_div_reg;
  logic [8:0] fbd_reg;
  logic [5:0] tune_reg;
  logic [2:0] new_sel_reg;
  logic swreq_reg;
  logic refused_reg;

  // Captured configuration
  logic cfg_done_reg;
  logic [2:0] init_sel_reg;
  logic [1:0] pmode_reg;
  logic pin_cfg_reg;

  // Oscillators and selection
  logic [23:0] frc_phase_reg;
  logic [23:0] low_power_rc_osc_phase_reg;
  logic frc_tick_reg;
  logic low_power_rc_osc_tick_reg;
  logic [2:0] cur_sel_reg;
  osp_sw_state_t sw_state_reg;
  logic [2:0] gap_cnt_reg;
  osp_pll_cfg_t pll_cfg_reg;
  logic [11:0] pll_acc_reg;
  logic pll_tick_reg;
  logic fcy_level_reg;

  logic wr_ctrl;
  logic req_switch;
  logic req_illegal;
  logic [23:0] frc_inc;
  logic [24:0] frc_sum;
  logic [24:0] low_power_rc_osc_sum;
  logic frc_post_tick;
  logic frc_div16_tick;
  logic fcy_div_tick;
  logic src_tick;
  logic pll_in_tick;
  logic pll_sel;
  logic [9:0] pll_m;
  logic [9:0] pll_den;
  logic pll_emit;
  logic [12:0] pll_sum;
  logic pin_free;
  logic [15:0] osc_ctrl_view;
  logic [15:0] rdata_next;

  assign wr_ctrl = bus.wr && (bus.addr == `OSP_ADDR_OSC_CTRL);
  assign req_switch = wr_ctrl && bus.wdata[`OSP_OC_SWREQ_BIT];
  assign req_illegal = req_switch && (
    (cur_sel_reg == `OSP_SEL_PRI_PLL
      && bus.wdata[`OSP_OC_NEW_LSB +: 3] == `OSP_SEL_FRC_PLL) ||
    (cur_sel_reg == `OSP_SEL_FRC_PLL
      && bus.wdata[`OSP_OC_NEW_LSB +: 3] == `OSP_SEL_PRI_PLL));

  // Register writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clk_div_reg <= `OSP_CLK_DIV_RST;
      fbd_reg <= `OSP_PLL_FBD_RST;
      tune_reg <= `OSP_FRC_TUNE_RST;
    end
    else if (bus.wr)
    begin
      if (bus.addr == `OSP_ADDR_CLK_DIV)
      begin
        clk_div_reg <= bus.wdata & 16'h07DF;
      end
      if (bus.addr == `OSP_ADDR_PLL_FBD)
      begin
        fbd_reg <= bus.wdata[8:0];
      end
      if (bus.addr == `OSP_ADDR_FRC_TUNE)
      begin
        tune_reg <= bus.wdata[5:0];
      end
    end
  end

  // Refused-switch flag; a new refusal wins over a clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      refused_reg <= 1'b0;
    end
    else if (req_illegal)
    begin
      refused_reg <= 1'b1;
    end
    else if (wr_ctrl && bus.wdata[`OSP_OC_REFUSED_BIT])
    begin
      refused_reg <= 1'b0;
    end
  end

  // Configuration capture in the first cycle after reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_done_reg <= 1'b0;
      init_sel_reg <= `OSP_SEL_FRC_DIVN;
      pmode_reg <= `OSP_PM_EC;
      pin_cfg_reg <= 1'b0;
    end
    else if (!cfg_done_reg)
    begin
      cfg_done_reg <= 1'b1;
      init_sel_reg <= cfg_programmed ? initial_osc_sel : `OSP_SEL_FRC_DIVN;
      pmode_reg <= primary_osc_mode_sel;
      pin_cfg_reg <= osc_pin_function_cfg;
    end
  end

  // Source selection and switch sequence
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur_sel_reg <= `OSP_SEL_FRC_DIVN;
      new_sel_reg <= `OSP_SEL_FRC_DIVN;
      swreq_reg <= 1'b0;
      sw_state_reg <= OSP_RUN;
      gap_cnt_reg <= 3'd0;
    end
    else if (!cfg_done_reg)
    begin
      cur_sel_reg <= cfg_programmed ? initial_osc_sel : `OSP_SEL_FRC_DIVN;
      new_sel_reg <= cfg_programmed ? initial_osc_sel : `OSP_SEL_FRC_DIVN;
    end
    else
    begin
      if (wr_ctrl && sw_state_reg == OSP_RUN && !swreq_reg)
      begin
        new_sel_reg <= bus.wdata[`OSP_OC_NEW_LSB +: 3];
        swreq_reg <= req_switch && !req_illegal;
      end
      unique case (sw_state_reg)
        OSP_RUN:
        begin
          if (swreq_reg)
          begin
            sw_state_reg <= OSP_DRAIN;
            gap_cnt_reg <= 3'd0;
          end
        end
        OSP_DRAIN:
        begin
          if (gap_cnt_reg == 3'(`OSP_SWITCH_GAP - 1))
          begin
            cur_sel_reg <= new_sel_reg;
            swreq_reg <= 1'b0;
            sw_state_reg <= OSP_RUN;
          end
          else
          begin
            gap_cnt_reg <= gap_cnt_reg + 3'd1;
          end
        end
      endcase
    end
  end

  // Fast RC and low-power RC phase accumulators
  assign frc_inc = FRC_INC + 24'({{18{tune_reg[5]}}, tune_reg} * TUNE_STEP);
  assign frc_sum = {1'b0, frc_phase_reg} + {1'b0, frc_inc};
  assign low_power_rc_osc_sum = {1'b0, low_power_rc_osc_phase_reg} + {1'b0, LOW_POWER_RC_OSC_INC};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      frc_phase_reg <= 24'h000000;
      low_power_rc_osc_phase_reg <= 24'h000000;
      frc_tick_reg <= 1'b0;
      low_power_rc_osc_tick_reg <= 1'b0;
    end
    else
    begin
      frc_phase_reg <= frc_sum[23:0];
      frc_tick_reg <= frc_sum[24];
      low_power_rc_osc_phase_reg <= low_power_rc_osc_sum[23:0];
      low_power_rc_osc_tick_reg <= low_power_rc_osc_sum[24];
    end
  end

  osp_tick_div #(.W(9)) u_frc_post (
    .clk(clk),
    .srst(srst),
    .tick_in(frc_tick_reg),
    .div(frc_post_div(clk_div_reg[`OSP_CD_FAST_RC_POSTSCALE_SEL_LSB +: 3])),
    .tick_out(frc_post_tick)
  );

  osp_tick_div #(.W(9)) u_frc_div16 (
    .clk(clk),
    .srst(srst),
    .tick_in(frc_tick_reg),
    .div(9'(`OSP_DIV16)),
    .tick_out(frc_div16_tick)
  );

  // PLL input and held settings
  assign pll_sel = is_pll_sel(cur_sel_reg);

  always_comb
  begin
    pll_in_tick = 1'b0;
    if (cur_sel_reg == `OSP_SEL_PRI_PLL)
    begin
      pll_in_tick = primary_tick;
    end
    else if (cur_sel_reg == `OSP_SEL_FRC_PLL)
    begin
      pll_in_tick = frc_tick_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pll_cfg_reg <= '{post: 2'(`OSP_CLK_DIV_RST >> `OSP_CD_POST_LSB),
        pre: 5'(`OSP_CLK_DIV_RST >> `OSP_CD_PRE_LSB), fbd: `OSP_PLL_FBD_RST};
    end
    else if (!pll_sel || sw_state_reg == OSP_DRAIN)
    begin
      pll_cfg_reg.post <= clk_div_reg[`OSP_CD_POST_LSB +: 2];
      pll_cfg_reg.pre <= clk_div_reg[`OSP_CD_PRE_LSB +: 5];
      pll_cfg_reg.fbd <= fbd_reg;
    end
  end

  assign pll_m = {1'b0, pll_cfg_reg.fbd} + 10'(`OSP_FBD_OFFSET);
  assign pll_den = ({5'h00, pll_cfg_reg.pre} + 10'(`OSP_PRE_OFFSET))
    * {6'h00, pll_post_div(pll_cfg_reg.post)};
  assign pll_emit = ({2'b00, pll_acc_reg} >= {4'h0, pll_den});
  assign pll_sum = {1'b0, pll_acc_reg} + (pll_in_tick ? {3'b000, pll_m} : 13'h0000)
    - (pll_emit ? {3'b000, pll_den} : 13'h0000);

  // Output rate is input rate times M over N1*N2
  always_ff @(posedge clk)
  begin
    if (srst || !pll_sel)
    begin
      pll_acc_reg <= 12'h000;
      pll_tick_reg <= 1'b0;
    end
    else
    begin
      pll_acc_reg <= pll_sum[12] ? 12'hFFF : pll_sum[11:0];
      pll_tick_reg <= pll_emit;
    end
  end

  // Source decode
  always_comb
  begin
    unique case (cur_sel_reg)
      `OSP_SEL_FRC: src_tick = frc_tick_reg;
      `OSP_SEL_FRC_PLL: src_tick = pll_tick_reg;
      `OSP_SEL_PRI: src_tick = primary_tick;
      `OSP_SEL_PRI_PLL: src_tick = pll_tick_reg;
      `OSP_SEL_SEC: src_tick = secondary_tick;
      `OSP_SEL_LOW_POWER_RC_OSC: src_tick = low_power_rc_osc_tick_reg;
      `OSP_SEL_FRC_DIV16: src_tick = frc_div16_tick;
      `OSP_SEL_FRC_DIVN: src_tick = frc_post_tick;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fosc_tick <= 1'b0;
    end
    else
    begin
      fosc_tick <= src_tick && sw_state_reg == OSP_RUN && cfg_done_reg;
    end
  end

  osp_tick_div #(.W(2)) u_fcy (
    .clk(clk),
    .srst(srst),
    .tick_in(fosc_tick),
    .div(2'(`OSP_FCY_DIV)),
    .tick_out(fcy_div_tick)
  );

  // Derived clocks and references
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fcy_tick <= 1'b0;
      periph_tick <= 1'b0;
      wdt_ref_tick <= 1'b0;
      fail_safe_clock_monitor_ref_tick <= 1'b0;
      cur_osc_sel <= `OSP_SEL_FRC_DIVN;
      pll_active <= 1'b0;
    end
    else
    begin
      fcy_tick <= fcy_div_tick;
      periph_tick <= fcy_div_tick;
      wdt_ref_tick <= low_power_rc_osc_tick_reg;
      fail_safe_clock_monitor_ref_tick <= low_power_rc_osc_tick_reg;
      cur_osc_sel <= cur_sel_reg;
      pll_active <= pll_sel;
    end
  end

  // Oscillator output pin: primary sources in a non-EC mode own it, else clock out or released
  assign pin_free = !((cur_sel_reg == `OSP_SEL_PRI || cur_sel_reg == `OSP_SEL_PRI_PLL)
    && pmode_reg != `OSP_PM_EC);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fcy_level_reg <= 1'b0;
      osc_out_pin_o <= 1'b0;
      osc_out_pin_oe <= 1'b0;
    end
    else
    begin
      if (fcy_div_tick)
      begin
        fcy_level_reg <= !fcy_level_reg;
      end
      osc_out_pin_o <= fcy_level_reg;
      osc_out_pin_oe <= pin_free && !pin_cfg_reg;
    end
  end

  // Read path
  always_comb
  begin
    osc_ctrl_view = 16'h0000;
    osc_ctrl_view[`OSP_OC_CUR_LSB +: 3] = cur_sel_reg;
    osc_ctrl_view[`OSP_OC_NEW_LSB +: 3] = new_sel_reg;
    osc_ctrl_view[`OSP_OC_PLL_BIT] = pll_sel;
    osc_ctrl_view[`OSP_OC_REFUSED_BIT] = refused_reg;
    osc_ctrl_view[`OSP_OC_SWREQ_BIT] = swreq_reg;
    rdata_next = 16'h0000;
    unique case (bus.addr)
      `OSP_ADDR_OSC_CTRL: rdata_next = osc_ctrl_view;
      `OSP_ADDR_CLK_DIV: rdata_next = clk_div_reg;
      `OSP_ADDR_PLL_FBD: rdata_next = {7'h00, fbd_reg};
      `OSP_ADDR_FRC_TUNE: rdata_next = {10'h000, tune_reg};
      `OSP_ADDR_CFG_STAT: rdata_next = {10'h000, init_sel_reg, pin_cfg_reg, pmode_reg};
      default: rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata <= 16'h0000;
    end
    else
    begin
      rdata <= bus.rd ? rdata_next : 16'h0000;
    end
  end

endmodule

// [design/osp_tick_div.sv]
// Programmable divider of a one-cycle tick stream
`timescale 1ns/1ps
module osp_tick_div #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick_in,
  input wire logic [W-1:0] div,
  output logic tick_out
);

  logic [W-1:0] count_reg;
  logic last;

  // A divisor of zero behaves as one
  assign last = (div == '0) || (count_reg >= div - W'(1));

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count_reg <= '0;
      tick_out <= 1'b0;
    end
    else if (tick_in)
    begin
      count_reg <= last ? '0 : count_reg + W'(1);
      tick_out <= last;
    end
    else
    begin
      tick_out <= 1'b0;
    end
  end

endmodule

// [include/osp_map.svh]
// Register offsets, field positions, reset values and timing counts of the oscillator block
`ifndef OSP_MAP_SVH
`define OSP_MAP_SVH

`define OSP_ADDR_OSC_CTRL 8'h00
`define OSP_ADDR_CLK_DIV 8'h04
`define OSP_ADDR_PLL_FBD 8'h08
`define OSP_ADDR_FRC_TUNE 8'h0C
`define OSP_ADDR_CFG_STAT 8'h10

`define OSP_OC_CUR_LSB 12
`define OSP_OC_NEW_LSB 8
`define OSP_OC_PLL_BIT 5
`define OSP_OC_REFUSED_BIT 3
`define OSP_OC_SWREQ_BIT 0
`define OSP_CD_FAST_RC_POSTSCALE_SEL_LSB 8
`define OSP_CD_POST_LSB 6
`define OSP_CD_PRE_LSB 0
`define OSP_CS_PMODE_LSB 0
`define OSP_CS_PINCFG_BIT 2
`define OSP_CS_INIT_LSB 3

`define OSP_CLK_DIV_RST 16'h0040
`define OSP_PLL_FBD_RST 9'h030
`define OSP_FRC_TUNE_RST 6'h00

`define OSP_SEL_FRC 3'h0
`define OSP_SEL_FRC_PLL 3'h1
`define OSP_SEL_PRI 3'h2
`define OSP_SEL_PRI_PLL 3'h3
`define OSP_SEL_SEC 3'h4
`define OSP_SEL_LOW_POWER_RC_OSC 3'h5
`define OSP_SEL_FRC_DIV16 3'h6
`define OSP_SEL_FRC_DIVN 3'h7

`define OSP_PM_EC 2'h0
`define OSP_PM_XT 2'h1
`define OSP_PM_HS 2'h2

`define OSP_POST_DIV2 2'h0
`define OSP_POST_DIV4 2'h1
`define OSP_POST_DIV8 2'h3

`define OSP_PRE_OFFSET 2
`define OSP_FBD_OFFSET 2
`define OSP_DIV16 16
`define OSP_FCY_DIV 2

`define OSP_CLK_KHZ 125000
`define OSP_FRC_KHZ 7370
`define OSP_LOW_POWER_RC_OSC_HZ 32768
`define OSP_PHASE_BITS 24
`define OSP_SWITCH_GAP 4

`endif

// [include/osp_pkg.sv]
// Types shared by the oscillator block
package osp_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } osp_bus_req_t;

  typedef struct packed {
    logic [1:0] post;
    logic [4:0] pre;
    logic [8:0] fbd;
  } osp_pll_cfg_t;

  typedef enum logic [1:0] {
    OSP_RUN,
    OSP_DRAIN
  } osp_sw_state_t;

endpackage
